// ===== verilog/vov_pkg.sv
// vov_pkg: constants for the vertical overflow and row scan block.
// assumes an indexed register port on the character clock domain.
//
// Function
// - sync start = low byte, bits 7,2
// - display end = low byte, bits 6,1
// - vertical total = low byte, bits 5,0
// - line compare = low byte, bit 4, height bit 6
// - address counter zeroed at line compare
// - blank start = low byte, bit 3, height bit 5
// - active area starts line zero, end index
// - sync begins on line equal start
// - blanking begins on line equal start
// - overflow bits protected except bit four
// - overflow bits five and zero reset zero
// - byte panning shifts zero to three characters
// - nine dot disable forces eight pixel step
// - fine pixel shift added to coarse shift
// - preset row scan selects first box line
// - preset register bit seven reads zero
// - seven bit index selects data register
// - double scanning halves row scan clock
package vov_pkg;
  localparam logic [6:0] IDX_VTOTAL = 7'h06;
  localparam logic [6:0] IDX_OVERFLOW = 7'h07;
  localparam logic [6:0] IDX_PRESET = 7'h08;
  localparam logic [6:0] IDX_HEIGHT = 7'h09;
  localparam logic [6:0] IDX_VSYNC = 7'h10;
  localparam logic [6:0] IDX_VDISP = 7'h12;
  localparam logic [6:0] IDX_VBLANK = 7'h15;
  localparam logic [6:0] IDX_SPLIT = 7'h18;
  // overflow field positions
  localparam int OV_VT8 = 0;
  localparam int OV_VDE8 = 1;
  localparam int OV_VSS8 = 2;
  localparam int OV_VBS8 = 3;
  localparam int OV_LC8 = 4;
  localparam int OV_VT9 = 5;
  localparam int OV_VDE9 = 6;
  localparam int OV_VSS9 = 7;
  // height control field positions
  localparam int HC_VBS9 = 5;
  localparam int HC_LC9 = 6;
  localparam int HC_DSCAN = 7;
  // overflow bits under group 0 protection (all but bit 4)
  localparam logic [7:0] OV_PROT_MASK = 8'hef;
  localparam logic [7:0] OV_RESET = 8'h00;
  localparam logic [7:0] HC_RESET = 8'h00;
  localparam logic [7:0] PRESET_RD_MASK = 8'h7f;
  localparam logic [5:0] STEP_NINE = 6'h09;
  localparam logic [5:0] STEP_EIGHT = 6'h08;
  localparam logic [9:0] LINE_ZERO = 10'h000;
endpackage : vov_pkg

// ===== verilog/vov_compose.sv
// vov_compose: builds the five 10-bit vertical values from register bits.
// assumes registers come from flip-flops in the same clock domain.
`timescale 1ns/1ps
module vov_compose (
  input wire logic [7:0] ovf,
  input wire logic [7:0] hgt,
  input wire logic [7:0] vt_lo,
  input wire logic [7:0] vde_lo,
  input wire logic [7:0] vss_lo,
  input wire logic [7:0] vbs_lo,
  input wire logic [7:0] lc_lo,
  output logic [9:0] v_total,
  output logic [9:0] v_disp_end,
  output logic [9:0] v_sync_start,
  output logic [9:0] v_blank_start,
  output logic [9:0] line_cmp
);
  // purely combinational so a write shows on the next compare
  // total bits
  assign v_total = {ovf[vov_pkg::OV_VT9], ovf[vov_pkg::OV_VT8], vt_lo};
  assign v_disp_end = {ovf[vov_pkg::OV_VDE9], ovf[vov_pkg::OV_VDE8], vde_lo};
  assign v_sync_start = {ovf[vov_pkg::OV_VSS9], ovf[vov_pkg::OV_VSS8],
                         vss_lo};
  assign v_blank_start = {hgt[vov_pkg::HC_VBS9], ovf[vov_pkg::OV_VBS8],
                          vbs_lo};
  assign line_cmp = {hgt[vov_pkg::HC_LC9], ovf[vov_pkg::OV_LC8], lc_lo};
endmodule : vov_compose

// ===== verilog/vov_pan.sv
// vov_pan: total horizontal pixel shift from coarse and fine panning.
// assumes pan fields come from registers on the same clock.
`timescale 1ns/1ps
module vov_pan (
  input wire logic [1:0] byte_pan,
  input wire logic nine_dot,
  input wire logic nine_dot_disable,
  input wire logic [3:0] fine_shift,
  output logic [5:0] pixel_shift
);
  logic [5:0] step;
  logic [5:0] coarse;
  assign step = (nine_dot && !nine_dot_disable) ? vov_pkg::STEP_NINE
                                                : vov_pkg::STEP_EIGHT;
  assign coarse = 6'((byte_pan[0] ? step : 6'h00)
                   + (byte_pan[1] ? 6'(step << 1) : 6'h00));
  // add fine shift; max 27+15 fits six bits
  assign pixel_shift = 6'(coarse + {2'h0, fine_shift});
endmodule : vov_pan

// ===== verilog/vov_timing.sv
// vov_timing: vertical overflow/row scan registers and vertical counters.
// assumes an indexed data port; line_end pulses once per scan line, from
// the horizontal timing logic on mclk.
`timescale 1ns/1ps
module vov_timing (
  input wire logic mclk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic idx_wr,
  input wire logic [7:0] idx_wdata,
  output logic [7:0] idx_rdata,
  input wire logic data_wr,
  input wire logic data_rd,
  input wire logic [7:0] data_wdata,
  output logic [7:0] data_rdata,
  input wire logic group0_protect,
  input wire logic [7:0] vertical_total_low_byte,
  input wire logic [7:0] vertical_sync_start_low_byte,
  input wire logic [7:0] vertical_display_end_low_byte,
  input wire logic [7:0] vertical_blank_start_low_byte,
  input wire logic [7:0] split_line_low_byte,
  input wire logic [3:0] fine_pixel_shift,
  input wire logic nine_dot_mode,
  input wire logic nine_dot_disable,
  input wire logic line_end,
  output logic [9:0] scan_line,
  output logic [4:0] row_scan,
  output logic display_active,
  output logic vsync,
  output logic vblank,
  output logic mem_addr_zero,
  output logic split_active,
  output logic frame_start,
  output logic [5:0] pixel_shift,
  output logic [9:0] v_total,
  output logic [9:0] v_disp_end,
  output logic [9:0] v_sync_start,
  output logic [9:0] v_blank_start,
  output logic [9:0] line_cmp
);
  typedef enum logic [1:0] {
    VOV_ACTIVE,
    VOV_BORDER,
    VOV_SYNC
  } vov_phase_e;

  typedef struct packed {
    logic [6:0] index;
    logic [7:0] overflow;
    logic [7:0] preset;
    logic [7:0] height;
    logic [7:0] rdata;
    logic [9:0] line;
    logic [4:0] row;
    logic dscan_half;
    logic split;
    logic zero_pulse;
    logic frame_pulse;
    logic vsync;
    logic vblank;
    vov_phase_e phase;
  } vov_state_s;

  vov_state_s st_q;
  vov_state_s st_d;

  // line-match helper, used by every vertical compare
  function automatic logic at_line(input logic [9:0] cnt,
                                   input logic [9:0] val);
    at_line = (cnt == val);
  endfunction : at_line

  function automatic logic [7:0] reg_read(input vov_state_s s,
                                          input logic [6:0] idx);
    case (idx)
      vov_pkg::IDX_OVERFLOW: reg_read = s.overflow;
      vov_pkg::IDX_PRESET: reg_read = s.preset & vov_pkg::PRESET_RD_MASK;
      vov_pkg::IDX_HEIGHT: reg_read = s.height;
      default: reg_read = 8'h00;
    endcase
  endfunction : reg_read

  vov_compose u_compose (
    .ovf(st_q.overflow),
    .hgt(st_q.height),
    .vt_lo(vertical_total_low_byte),
    .vde_lo(vertical_display_end_low_byte),
    .vss_lo(vertical_sync_start_low_byte),
    .vbs_lo(vertical_blank_start_low_byte),
    .lc_lo(split_line_low_byte),
    .v_total(v_total),
    .v_disp_end(v_disp_end),
    .v_sync_start(v_sync_start),
    .v_blank_start(v_blank_start),
    .line_cmp(line_cmp)
  );

  vov_pan u_pan (
    .byte_pan(st_q.preset[6:5]),
    .nine_dot(nine_dot_mode),
    .nine_dot_disable(nine_dot_disable),
    .fine_shift(fine_pixel_shift),
    .pixel_shift(pixel_shift)
  );

  logic last_line;
  logic row_tick;
  logic [4:0] row_first;
  logic [4:0] row_max;
  logic [9:0] next_line;

  // wrap at total; total holds lines minus two, so last index is +1
  assign last_line = at_line(st_q.line, 10'(v_total + 10'h001));
  assign next_line = last_line ? vov_pkg::LINE_ZERO
                               : 10'(st_q.line + 10'h001);
  assign row_tick = line_end &&
                    (!st_q.height[vov_pkg::HC_DSCAN] || st_q.dscan_half);
  assign row_max = st_q.height[4:0];
  assign row_first = st_q.preset[4:0];

  // next-state for registers and counters
  always_comb begin
    st_d = st_q;
    st_d.zero_pulse = 1'b0;
    st_d.frame_pulse = 1'b0;
    if (idx_wr) begin
      st_d.index = idx_wdata[6:0];
    end
    if (data_wr) begin
      case (st_q.index)
        vov_pkg::IDX_OVERFLOW: begin
          if (group0_protect) begin
            st_d.overflow = (st_q.overflow & vov_pkg::OV_PROT_MASK) |
                            (data_wdata & ~vov_pkg::OV_PROT_MASK);
          end else begin
            st_d.overflow = data_wdata;
          end
        end
        vov_pkg::IDX_PRESET: st_d.preset = data_wdata;
        vov_pkg::IDX_HEIGHT: st_d.height = data_wdata;
        default: ;
      endcase
    end
    if (data_rd) begin
      st_d.rdata = reg_read(st_q, st_q.index);
    end
    if (line_end) begin
      st_d.line = next_line;
      st_d.dscan_half = ~st_q.dscan_half;
      if (last_line) begin
        // new frame: line zero active, top row begins at preset scan
        // start line zero
        st_d.frame_pulse = 1'b1;
        st_d.row = row_first;
        st_d.split = 1'b0;
        st_d.dscan_half = 1'b0;
        st_d.phase = VOV_ACTIVE;
        st_d.vsync = 1'b0;
        st_d.vblank = 1'b0;
      end else begin
        if (row_tick) begin
          if (st_q.row >= row_max) begin
            st_d.row = 5'h00;
          end else begin
            st_d.row = 5'(st_q.row + 5'h01);
          end
        end
        if (at_line(next_line, line_cmp)) begin
          st_d.split = 1'b1;
          st_d.zero_pulse = 1'b1;
          st_d.row = 5'h00;
        end
        if (at_line(next_line, v_blank_start)) begin
          st_d.vblank = 1'b1;
        end
        if (at_line(next_line, v_sync_start)) begin
          st_d.vsync = 1'b1;
          // sync inside the active area must not cut the display short
          if (st_q.phase != VOV_ACTIVE) begin
            st_d.phase = VOV_SYNC;
          end
        end
        case (st_q.phase)
          VOV_ACTIVE: begin
            if (at_line(st_q.line, v_disp_end)) begin
              st_d.phase = VOV_BORDER;
            end
          end
          VOV_BORDER: ;
          VOV_SYNC: ;
          default: st_d.phase = VOV_BORDER;
        endcase
      end
    end
  end

  // state register; clk_en freezes everything
  always_ff @(posedge mclk) begin
    if (reset) begin
      st_q <= '0;
      st_q.overflow <= vov_pkg::OV_RESET;
      st_q.height <= vov_pkg::HC_RESET;
      st_q.phase <= VOV_ACTIVE;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  assign scan_line = st_q.line;
  assign row_scan = st_q.row;
  assign display_active = (st_q.phase == VOV_ACTIVE);
  assign vsync = st_q.vsync;
  assign vblank = st_q.vblank;
  assign mem_addr_zero = st_q.zero_pulse;
  assign split_active = st_q.split;
  assign frame_start = st_q.frame_pulse;
  assign data_rdata = st_q.rdata;
  assign idx_rdata = {1'b0, st_q.index};
endmodule : vov_timing

// ===== sim/vov_timing_monitor.sv
// vov_timing_monitor: concurrent checks on the vertical timing ports.
// assumes it is bound into vov_timing and sees only its ports.
`timescale 1ns/1ps
module vov_timing_monitor (
  input wire logic mclk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic line_end,
  input wire logic [7:0] vertical_total_low_byte,
  input wire logic [7:0] vertical_sync_start_low_byte,
  input wire logic [9:0] scan_line,
  input wire logic [9:0] v_total,
  input wire logic [9:0] v_sync_start,
  input wire logic [9:0] v_disp_end,
  input wire logic [9:0] line_cmp,
  input wire logic display_active,
  input wire logic vsync,
  input wire logic mem_addr_zero,
  input wire logic frame_start
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // a line end taken while the counter sits on the final line
  sequence last_line;
    clk_en && line_end && scan_line == v_total + 10'h001;
  endsequence
  vt_low_a: assert property (v_total[7:0] == vertical_total_low_byte)
    else $error("vertical total low byte wrong");
  vss_low_a:
    assert property (v_sync_start[7:0] == vertical_sync_start_low_byte)
    else $error("sync start low byte wrong");
  frame_wrap_a:
    assert property (last_line |=> scan_line == 10'h000 && frame_start)
    else $error("frame did not wrap to line zero");
  line_step_a:
    assert property (clk_en && line_end && scan_line != v_total + 10'h001
      |=> scan_line == $past(scan_line) + 10'h001)
    else $error("scan line did not advance by one");
  frame_zero_a: assert property (frame_start |-> scan_line == 10'h000)
    else $error("frame start away from line zero");
  sync_line_a: assert property ($rose(vsync) |-> scan_line == v_sync_start)
    else $error("sync began on the wrong line");
  split_line_a: assert property (mem_addr_zero |-> scan_line == line_cmp)
    else $error("address reset on the wrong line");
  disp_end_a:
    assert property ($fell(display_active) |-> $past(scan_line) == v_disp_end)
    else $error("display ended on the wrong line");
endmodule : vov_timing_monitor

bind vov_timing vov_timing_monitor mon_u (.*);

// ===== sim/vov_crt_model.sv
// vov_crt_model: display side; paces scan lines, counts lines per frame.
// assumes frame_start pulses once per frame on mclk.
`timescale 1ns/1ps
module vov_crt_model #(parameter int LINE_LEN = 4) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic run,
  input wire logic frame_start,
  output logic line_end,
  output logic [9:0] lines
);
  int ph;
  logic [9:0] cnt;
  // line pacing and frame count; pulses never back to back
  always_ff @(posedge mclk) begin
    ph <= (reset || !run || ph == LINE_LEN - 1) ? 0 : ph + 1;
    line_end <= run && !reset && ph == LINE_LEN - 1;
    cnt <= (reset || frame_start) ? 10'h000 : 10'(cnt + 10'(line_end));
    if (reset) begin
      lines <= 10'h000;
    end else if (frame_start) begin
      lines <= cnt;
    end
  end
endmodule : vov_crt_model

// ===== sim/vov_timing_tb.sv
// vov_timing_tb: random and corner tests of the vertical timing block.
// assumes the design, its monitor and vov_crt_model are compiled first.
`timescale 1ns/1ps
module vov_timing_tb;
  logic mclk, reset, clk_en, idx_wr, data_wr, data_rd, group0_protect;
  logic nine_dot_mode, nine_dot_disable, line_end, run, frame_start;
  logic display_active, vsync, vblank, mem_addr_zero, split_active;
  logic [7:0] idx_wdata, data_wdata, idx_rdata, data_rdata;
  logic [7:0] vt, vs, vd, vb, lc, ov, hc, pr, q;
  logic [3:0] fine_pixel_shift;
  logic [4:0] row_scan;
  logic [5:0] pixel_shift;
  logic [9:0] scan_line, v_total, v_disp_end, v_sync_start, v_blank_start;
  logic [9:0] line_cmp, lines;
  int failures, checks_done, cyc;

  vov_timing dut_u (.*, .vertical_total_low_byte(vt),
    .vertical_sync_start_low_byte(vs), .vertical_display_end_low_byte(vd),
    .vertical_blank_start_low_byte(vb), .split_line_low_byte(lc));
  vov_crt_model #(.LINE_LEN(4)) crt_u (.*);

  initial begin
    mclk = 1'h0;
    forever #4 mclk = ~mclk;
  end
  // hang guard: the whole run needs far fewer cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      close_out();
    end
  end

  task automatic chk(input string n, input logic [9:0] e, input logic [9:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // one indexed access: index cycle, then a data write or read pulse
  task automatic acc(input logic [6:0] i, input logic w, input logic [7:0] d,
      output logic [7:0] r);
    @(posedge mclk);
    idx_wr <= 1'h1;
    idx_wdata <= {1'h0, i};
    @(posedge mclk);
    idx_wr <= 1'h0;
    data_wr <= w;
    data_rd <= !w;
    data_wdata <= d;
    @(posedge mclk);
    data_wr <= 1'h0;
    data_rd <= 1'h0;
    #1;
    r = data_rdata;
  endtask : acc
  function automatic logic [9:0] cmp(input logic b9, b8, input logic [7:0] lo);
    return {b9, b8, lo};
  endfunction : cmp
  function automatic logic [5:0] pan(input logic [1:0] bp, input logic n9,
      input logic off, input logic [3:0] f);
    return (n9 && !off ? 6'h09 : 6'h08) * {4'h0, bp} + {2'h0, f};
  endfunction : pan
  task automatic comp;
    chk("vtotal", cmp(ov[5], ov[0], vt), v_total);
    chk("vsync", cmp(ov[7], ov[2], vs), v_sync_start);
    chk("vdisp", cmp(ov[6], ov[1], vd), v_disp_end);
    chk("vblank", cmp(hc[5], ov[3], vb), v_blank_start);
    chk("lcmp", cmp(hc[6], ov[4], lc), line_cmp);
  endtask : comp
  task automatic wait_frame;
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while (frame_start !== 1'h1 && n < 500);
    chk("frame_seen", 10'h001, {9'h0, frame_start});
  endtask : wait_frame
  task automatic wait_line(input logic [9:0] l);
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while (scan_line !== l && n < 100);
    chk("line_seen", l, scan_line);
  endtask : wait_line
  task automatic close_out;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out

  initial begin
    {idx_wr, data_wr, data_rd, group0_protect, run, clk_en} = 6'h01;
    {nine_dot_mode, nine_dot_disable, fine_pixel_shift} = '0;
    {idx_wdata, data_wdata, vt, vs, vd, vb, lc, ov, hc} = '0;
    reset = 1'h1;
    void'($urandom(10));
    repeat (3) @(posedge mclk);
    reset <= 1'h0;
    acc(7'h07, 1'h0, 8'h00, q);
    chk("ovf_reset", 10'h000, {2'h0, q & 8'h21});
    acc(7'h09, 1'h0, 8'h00, q);
    chk("hgt_reset", 10'h000, {2'h0, q});
    $display("test reset done");
    // random composites with all-ones and all-zeros overflow corners
    for (int i = 0; i < 8; i++) begin
      ov = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom);
      hc = 8'($urandom);
      @(posedge mclk);
      {vt, vs, vd, vb, lc} <= 40'({$urandom, $urandom});
      acc(7'h07, 1'h1, ov, q);
      acc(7'h09, 1'h1, hc, q);
      comp();
      acc(7'h07, 1'h0, 8'h00, q);
      chk("ovf_rd", {2'h0, ov}, {2'h0, q});
    end
    // under protection only line compare bit 8 may change
    @(posedge mclk);
    group0_protect <= 1'h1;
    acc(7'h07, 1'h1, ~ov, q);
    ov = (ov & 8'hef) | (~ov & 8'h10);
    acc(7'h07, 1'h0, 8'h00, q);
    chk("ovf_prot", {2'h0, ov}, {2'h0, q});
    comp();
    @(posedge mclk);
    group0_protect <= 1'h0;
    $display("test compose done");
    // every byte pan code in 9-dot, 8-dot and 9-dot-disabled modes
    for (int i = 0; i < 16; i++) begin
      @(posedge mclk);
      {nine_dot_disable, nine_dot_mode} <= 2'(i >> 2);
      fine_pixel_shift <= 4'($urandom);
      pr = {1'h1, 2'(i), 5'($urandom)};
      acc(7'h08, 1'h1, pr, q);
      acc(7'h08, 1'h0, 8'h00, q);
      chk("preset_rd", {2'h0, pr & 8'h7f}, {2'h0, q});
      chk("pan", {4'h0, pan(pr[6:5], nine_dot_mode, nine_dot_disable,
        fine_pixel_shift)}, {4'h0, pixel_shift});
    end
    acc(7'h7f, 1'h1, 8'hff, q);
    acc(7'h7f, 1'h0, 8'h00, q);
    chk("unmapped", 10'h000, {2'h0, q});
    chk("idx_rd", 10'h07f, {2'h0, idx_rdata});
    $display("test preset done");
    // 12-line frame, 3-line rows, top row starting on box line 2
    {ov, hc} = 16'h0002;
    @(posedge mclk);
    {vt, vs, vd, vb, lc} <= 40'h0a08050703;
    acc(7'h07, 1'h1, ov, q);
    acc(7'h09, 1'h1, hc, q);
    acc(7'h08, 1'h1, 8'h02, q);
    comp();
    @(posedge mclk);
    run <= 1'h1;
    wait_frame();
    chk("row_start", 10'h002, {5'h0, row_scan});
    wait_frame();
    @(posedge mclk);
    #1;
    chk("frame_lines", 10'h00c, lines);
    $display("test frame done");
    // double scan rows, preset row left at zero as software should
    acc(7'h09, 1'h1, 8'h82, q);
    acc(7'h08, 1'h1, 8'h00, q);
    wait_frame();
    chk("row_zero", 10'h000, {5'h0, row_scan});
    wait_line(10'h002);
    chk("dscan_row", 10'h001, {5'h0, row_scan});
    chk("split_early", 10'h000, {9'h0, split_active});
    chk("blank_early", 10'h000, {9'h0, vblank});
    wait_line(10'h008);
    chk("split_on", 10'h001, {9'h0, split_active});
    chk("blank_on", 10'h001, {9'h0, vblank});
    chk("sync_on", 10'h001, {9'h0, vsync});
    chk("disp_off", 10'h000, {9'h0, display_active});
    // clock enable low must hold the line counter across two line ends
    @(posedge mclk);
    clk_en <= 1'h0;
    repeat (8) @(posedge mclk);
    #1;
    chk("freeze", 10'h008, scan_line);
    @(posedge mclk);
    clk_en <= 1'h1;
    $display("test scan done");
    close_out();
  end
endmodule : vov_timing_tb
